// [gdl_port.v]
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`include "gdl_regs.vh"
// ----------------------------------------------------------------------
// four pin direction and level port, classic wishbone slave
// ----------------------------------------------------------------------
module gdl_port
(
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  input  wire [3:0]  pin_in,
  output reg  [3:0]  pin_out,
  output reg  [3:0]  pin_oe_n
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [3:0] pin_direction_bits_q;
  reg  [3:0] out_level_q;
  wire [3:0] pin_sync;
  wire [3:0] pin_level_bits;
  wire       req;
  wire       hit_dir;
  wire       hit_raw;
  wire [3:0] wr_level;

  // decode one of our word offsets
  function hit;
    input [3:0] adr;
    input [3:0] off;
    begin
      hit = (adr == off);
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------------
  // sync pins twice
  gdl_sync #(.WIDTH(`GDL_PINS)) u_sync
  (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit_dir = hit(wb_adr_i, `GDL_OFF_DIR_LEVEL);
  assign hit_raw = hit(wb_adr_i, `GDL_OFF_RAW_PINS);

  assign pin_level_bits = (pin_direction_bits_q & out_level_q)
                        | (~pin_direction_bits_q & pin_sync);

  // input bits ignore writes; direction from same write applies
  assign wr_level = (wb_dat_i[`GDL_DIR_MSB:`GDL_DIR_LSB] & wb_dat_i[3:0])
                  | (~wb_dat_i[`GDL_DIR_MSB:`GDL_DIR_LSB] & out_level_q);

  // ----------------------------------------------------------------------
  // register write
  // ----------------------------------------------------------------------
  // reset clears all
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_direction_bits_q <= 4'h0;
      out_level_q          <= 4'h0;
    end
    else if (req && wb_we_i && hit_dir && wb_sel_i[0])
    begin
      pin_direction_bits_q <= wb_dat_i[`GDL_DIR_MSB:`GDL_DIR_LSB];
      out_level_q          <= wr_level;
    end
  end

  // ----------------------------------------------------------------------
  // bus answer, one cycle after request
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & (hit_dir | hit_raw);
      wb_err_o <= req & ~(hit_dir | hit_raw);
      if (req && hit_dir)
        wb_dat_o <= {24'h00_0000, pin_direction_bits_q, pin_level_bits};
      else if (req && hit_raw)
        wb_dat_o <= {28'h000_0000, pin_sync};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // open drain pins, oe low while pulling down
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out  <= 4'h0;
      pin_oe_n <= 4'hF;
    end
    else
    begin
      pin_out  <= 4'h0; // only ever drives low
      pin_oe_n <= ~(pin_direction_bits_q & out_level_q);
    end
  end

endmodule

// [gdl_regs.vh]
// Function
// - bits 7 to 4 choose per pin direction, 0 input, 1 output.
// - output pin with level bit 1 turns pulldown on, pin low.
// - output pin with level bit 0 leaves pin undriven; never driven high.
// - input pin level bit shows sampled pin, 0 low, 1 high.
// - writes skip level bits of input pins; output pin bits still update.
`ifndef GDL_REGS_VH
`define GDL_REGS_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define GDL_ADDR_W          4
`define GDL_OFF_DIR_LEVEL   4'h0
`define GDL_OFF_RAW_PINS    4'h4

// ----------------------------------------------------------------------
// field layout and reset
// ----------------------------------------------------------------------
`define GDL_PINS            4
`define GDL_DIR_MSB         7
`define GDL_DIR_LSB         4
`define GDL_LEVEL_MSB       3
`define GDL_LEVEL_LSB       0
`define GDL_RESET_VALUE     8'h00

`endif

// [gdl_sync.v]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// two flop synchroniser, per bit
// ----------------------------------------------------------------------
module gdl_sync
#(
  parameter WIDTH = 4
)
(
  input  wire             clk_sys,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [gdl_chk_props.sv]
`timescale 1ns/100ps
// ------------------------------
// port checker
// ------------------------------
module gdl_chk
(
  input wire        clk_sys,
  input wire        reset_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire [3:0]  pin_out,
  input wire [3:0]  pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  sequence s_wr; wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0; endsequence
  // answer one cycle after take, ack one cycle long
  a_answer_next: assert property (s_take |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o)
    else $error("ack");
  a_never_high: assert property (pin_out == 4'h0) else $error("high");
  a_oe_write: assert property (s_wr |=> pin_oe_n == ~($past(wb_dat_i[7:4]) & $past(wb_dat_i[3:0])))
    else $error("oe");
  a_read_dir: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |->
    wb_dat_o[31:8] == 24'h0 && pin_oe_n == ~(wb_dat_o[7:4] & wb_dat_o[3:0])) else $error("rd");
  a_oe_hold: assert property ($changed(pin_oe_n) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("hold");
  a_reset_idle: assert property ($rose(reset_n) |-> pin_oe_n == 4'hF) else $error("rst");
endmodule
bind gdl_port gdl_chk chk (.*);

// [gdl_pullups.sv]
`timescale 1ns/100ps
module gdl_pullups
(
  input  wire [3:0] pin_oe_n,
  input  wire [3:0] ext_low,
  output wire [3:0] pin_lvl
);
  // pull-up sets the level unless someone pulls low
  assign pin_lvl = pin_oe_n & ~ext_low;
endmodule

// [testbench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
  reg          clk_sys = 0, reset_n = 0, cyc = 0, we = 0;
  reg  [3:0]   adr = 0, sel = 4'hF, ext_low = 0;
  reg  [31:0]  dat = 0;
  wire [31:0]  rd;
  wire         ack, err;
  wire [3:0]   pin_in, pin_out, oe_n;
  int          bad_count = 0, samples_checked = 0;
  logic [31:0] exp_q[$];
  logic [7:0]  d;
  gdl_port dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n));
  gdl_pullups ext (.pin_oe_n(oe_n), .ext_low(ext_low), .pin_lvl(pin_in));
  initial forever #5 clk_sys = ~clk_sys;
  // read answers against the oldest note
  always @(posedge clk_sys)
    if (ack && !we)
    begin
      if (exp_q.size() > 0)
        `CHK(rd, exp_q.pop_front())
      else
        bad_count++;
    end
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one classic cycle, held until ack or err
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    int n;
    @(posedge clk_sys);
    cyc <= 1; we <= w; adr <= a; dat <= {24'h0, v};
    for (n = 0; n < 20 && !(ack || err); n++) @(posedge clk_sys);
    if (n >= 20) begin bad_count++; test_done(); end
    cyc <= 0;
  endtask
  initial begin
    void'($urandom(32'hb70ebf05));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1;
    // let the pin synchroniser fill before the first read
    repeat (2) @(posedge clk_sys);
    exp_q.push_back(32'h0F);
    bus(0, 0, 0);
    bus(1, 4'h8, 8'hFF);
    `CHK(err, 1'b1)
    sel <= 0;
    bus(1, 0, 8'hFF);
    sel <= 4'hF;
    exp_q.push_back(32'h0F);
    bus(0, 0, 0);
    repeat (40) begin
      d = 8'($urandom);
      ext_low <= 4'($urandom);
      bus(1, 0, d);
      repeat (3) @(posedge clk_sys);
      exp_q.push_back({24'h0, d[7:4], d[3:0] & d[7:4] | ~d[7:4] & ~ext_low});
      bus(0, 0, 0);
      `CHK(oe_n, ~(d[7:4] & d[3:0]))
      `CHK(pin_out, 4'h0)
      exp_q.push_back({28'h000_0000, pin_in});
      bus(0, 4'h4, 0);
    end
    test_done();
  end
endmodule
